/* rtl/phy_stat_pkg.sv */
// Purpose: constants and carriers for the management status block
// Assumes: 200 MHz core clock, 100 Mb/s bit time
// Notes: offsets are management register numbers
package phy_stat_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [4:0] CTRL_ADDR = 5'h00;
   localparam logic [4:0] STAT_ADDR = 5'h01;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] STAT_RESET = 16'h7809;
   localparam int CTRL_LOOP_BIT = 14;
   localparam int CTRL_COLT_BIT = 7;
   localparam int STAT_T4_BIT = 15;
   localparam int STAT_CAP_LSB = 11;
   localparam int STAT_CAP_W = 4;
   localparam int STAT_PRE_BIT = 6;
   localparam int STAT_AND_BIT = 5;
   localparam int STAT_RF_BIT = 4;
   localparam int STAT_ANA_BIT = 3;
   localparam int STAT_LINK_BIT = 2;
   localparam int STAT_JAB_BIT = 1;
   localparam int STAT_EXT_BIT = 0;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int BIT_TIME_PS = 10000;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int COL_ON_BT = 512;
   localparam int COL_OFF_BT = 4;
   // longest times round down
   localparam int COL_ON_CYC =
      COL_ON_BT * BIT_TIME_PS / CLK_PERIOD_PS;
   localparam int COL_OFF_CYC =
      COL_OFF_BT * BIT_TIME_PS / CLK_PERIOD_PS;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [15:0] wdata;
   } mgmt_req_t;

   typedef struct packed {
      logic an_enable;
      logic an_done;
      logic remote_fault;
      logic link_ok;
      logic jabber;
   } stat_ev_t;

endpackage : phy_stat_pkg

/* rtl/phy_stat_regs.sv */
// Purpose: control bit 7, reserved bits and status register
// Assumes: framing done outside; req is on clk
// Notes: tx_en and tx_clk are pins, synchronised here
`timescale 1ns/1ps

module phy_stat_regs (
   input wire logic clk,
   input wire logic resetn,
   input phy_stat_pkg::mgmt_req_t req,
   input wire logic override_writable,
   input phy_stat_pkg::stat_ev_t ev,
   input wire logic tx_en,
   input wire logic tx_clk,
   output logic [15:0] rdata,
   output logic rvalid,
   output logic col
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function automatic logic hit(
      input logic [4:0] a,
      input logic [4:0] t
   );
      hit = (a == t);
   endfunction : hit

   wire logic ctrl_sel;
   wire logic stat_sel;
   wire logic stat_rd;
   wire logic ctrl_wr;
   wire logic cap_wr;
   assign ctrl_sel = hit(req.addr, phy_stat_pkg::CTRL_ADDR);
   assign stat_sel = hit(req.addr, phy_stat_pkg::STAT_ADDR);
   // only register one reaches the status bits
   assign stat_rd = req.rd & stat_sel;
   assign ctrl_wr = req.wr & ctrl_sel;
   // override writable bits ignore writes unless enabled
   assign cap_wr = req.wr & stat_sel & override_writable;

   // ----------------------------------------
   // control bits
   // ----------------------------------------
   logic loop_q;
   logic col_test_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         loop_q <=
            phy_stat_pkg::CTRL_RESET[phy_stat_pkg::CTRL_LOOP_BIT];
         col_test_q <=
            phy_stat_pkg::CTRL_RESET[phy_stat_pkg::CTRL_COLT_BIT];
      end else if (ctrl_wr) begin
         loop_q <= req.wdata[phy_stat_pkg::CTRL_LOOP_BIT];
         col_test_q <= req.wdata[phy_stat_pkg::CTRL_COLT_BIT];
      end
   end

   wire logic [15:0] ctrl_view;
   // reserved low bits are never stored, so they read zero
   assign ctrl_view = {1'b0, loop_q, 6'h00, col_test_q,
                       7'h00};

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic txen_s1_q;
   logic txen_s2_q;
   logic txclk_s1_q;
   logic txclk_s2_q;
   logic txclk_s3_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txen_s1_q <= 1'b0;
         txen_s2_q <= 1'b0;
         txclk_s1_q <= 1'b0;
         txclk_s2_q <= 1'b0;
         txclk_s3_q <= 1'b0;
      end else begin
         txen_s1_q <= tx_en;
         txen_s2_q <= txen_s1_q;
         txclk_s1_q <= tx_clk;
         txclk_s2_q <= txclk_s1_q;
         txclk_s3_q <= txclk_s2_q;
      end
   end

   wire logic txclk_rise;
   assign txclk_rise = txclk_s2_q & ~txclk_s3_q;

   // ----------------------------------------
   // collision test path
   // ----------------------------------------
   // tx_en is taken at a link clock edge, as the MAC launches it;
   // the fall is seen at once so COL drops well inside 4 bit times.
   // loopback does not gate this path.
   logic armed_q;
   logic col_q;
   wire logic armed_d;
   wire logic col_d;
   assign armed_d = txen_s2_q & (armed_q | txclk_rise);
   assign col_d = col_test_q & armed_d;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         armed_q <= 1'b0;
         col_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
         col_q <= col_d;
      end
   end

   assign col = col_q;

   // ----------------------------------------
   // status: writable capability bits
   // ----------------------------------------
   logic [phy_stat_pkg::STAT_CAP_W-1:0] cap_q;
   logic pre_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cap_q <= phy_stat_pkg::STAT_RESET[
            phy_stat_pkg::STAT_CAP_LSB +: phy_stat_pkg::STAT_CAP_W];
         pre_q <=
            phy_stat_pkg::STAT_RESET[phy_stat_pkg::STAT_PRE_BIT];
      end else if (cap_wr) begin
         cap_q <= req.wdata[
            phy_stat_pkg::STAT_CAP_LSB +: phy_stat_pkg::STAT_CAP_W];
         pre_q <= req.wdata[phy_stat_pkg::STAT_PRE_BIT];
      end
   end

   // ----------------------------------------
   // status: latching flags
   // ----------------------------------------
   // index 2 negotiation done, 1 remote fault, 0 jabber
   wire logic [2:0] hi_live;
   assign hi_live = {ev.an_enable & ev.an_done,
                     ev.remote_fault,
                     ev.jabber};

   logic [2:0] hi_flag_q;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_hi_flag
         // a read reloads the live level, so an event in the
         // read cycle is kept rather than lost
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               hi_flag_q[gi] <= 1'b0;
            end else if (stat_rd) begin
               hi_flag_q[gi] <= hi_live[gi];
            end else begin
               hi_flag_q[gi] <= hi_flag_q[gi] | hi_live[gi];
            end
         end
      end
   endgenerate

   logic link_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link_q <= 1'b0;
      end else if (stat_rd) begin
         link_q <= ev.link_ok;
      end else begin
         link_q <= link_q & ev.link_ok;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // reserved status bits 10:7 are not stored and read zero
   wire logic [15:0] stat_view;
   assign stat_view = {1'b0,
                       cap_q,
                       4'h0,
                       pre_q,
                       hi_flag_q[2],
                       hi_flag_q[1],
                       1'b1,
                       link_q,
                       hi_flag_q[0],
                       1'b1};

   wire logic [15:0] rd_mux;
   assign rd_mux = stat_sel ? stat_view :
                   ctrl_sel ? ctrl_view : 16'h0000;

   logic [15:0] rdata_q;
   logic rvalid_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
         if (req.rd) begin
            rdata_q <= rd_mux;
         end
      end
   end

   assign rdata = rdata_q;
   assign rvalid = rvalid_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   localparam int col_on_max = phy_stat_pkg::COL_ON_CYC;
   localparam int col_off_max = phy_stat_pkg::COL_OFF_CYC;
   wire logic ctrl_rd;
   assign ctrl_rd = req.rd & ctrl_sel;

   property p_col_idle;
      @(posedge clk) disable iff (!resetn)
      !col_test_q |=> !col;
   endproperty
   a_col_idle: assert property (p_col_idle)
      else $error("col driven with collision test off");

   // cycles spent waiting for col; a link clock that never rises
   // while tx_en is high never arms the path, and this counter reports it
   logic [10:0] col_wait_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         col_wait_q <= 11'h000;
      end else if (col_test_q && txen_s2_q && !col_q) begin
         col_wait_q <= col_wait_q + 11'h001;
      end else begin
         col_wait_q <= 11'h000;
      end
   end

   property p_col_on;
      @(posedge clk) disable iff (!resetn)
      col_wait_q < 11'(col_on_max);
   endproperty
   a_col_on: assert property (p_col_on)
      else $error("col not asserted in time");

   property p_col_follow;
      @(posedge clk) disable iff (!resetn)
      col |-> $past(txen_s2_q) && $past(col_test_q);
   endproperty
   a_col_follow: assert property (p_col_follow)
      else $error("col without tx enable");

   property p_col_off;
      @(posedge clk) disable iff (!resetn)
      $fell(tx_en) |-> ##[0:col_off_max] !col;
   endproperty
   a_col_off: assert property (p_col_off)
      else $error("col held after tx enable fell");

   property p_ctrl_rsv;
      @(posedge clk) disable iff (!resetn)
      ctrl_rd |=> rvalid && rdata[6:0] == 7'h00;
   endproperty
   a_ctrl_rsv: assert property (p_ctrl_rsv)
      else $error("control reserved bits not zero");

   property p_fixed_bits;
      @(posedge clk) disable iff (!resetn)
      stat_rd |=> !rdata[15] && rdata[3] && rdata[0]
                  && rdata[10:7] == 4'h0;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits)
      else $error("fixed status bits wrong");

   property p_cap_hold;
      @(posedge clk) disable iff (!resetn)
      (req.wr && stat_sel && !override_writable) |=>
         $stable(cap_q) && $stable(pre_q);
   endproperty
   a_cap_hold: assert property (p_cap_hold)
      else $error("override bits written while locked");

   property p_hi_keep;
      @(posedge clk) disable iff (!resetn)
      (ev.jabber && !stat_rd) ##1 !stat_rd [*2] |->
         hi_flag_q[0];
   endproperty
   a_hi_keep: assert property (p_hi_keep)
      else $error("jabber flag lost before read");

   property p_lo_keep;
      @(posedge clk) disable iff (!resetn)
      (!ev.link_ok && !stat_rd) ##1 (ev.link_ok && !stat_rd)
         |=> !link_q;
   endproperty
   a_lo_keep: assert property (p_lo_keep)
      else $error("link flag recovered without read");

   property p_an_off;
      @(posedge clk) disable iff (!resetn)
      (stat_rd && !ev.an_enable) |=> !hi_flag_q[2];
   endproperty
   a_an_off: assert property (p_an_off)
      else $error("negotiation done set while disabled");

   property p_rf_read;
      @(posedge clk) disable iff (!resetn)
      (stat_rd && hi_flag_q[1]) |=> rdata[phy_stat_pkg::STAT_RF_BIT];
   endproperty
   a_rf_read: assert property (p_rf_read)
      else $error("remote fault not reported");

   c_col_test: cover property (@(posedge clk)
      disable iff (!resetn) col_test_q && loop_q && col);
   c_cap_write: cover property (@(posedge clk)
      disable iff (!resetn) cap_wr);
   c_jab_clear: cover property (@(posedge clk)
      disable iff (!resetn) stat_rd && hi_flag_q[0] ##1 !hi_flag_q[0]);
   c_link_up: cover property (@(posedge clk)
      disable iff (!resetn) stat_rd && ev.link_ok ##1 link_q);

endmodule : phy_stat_regs

/* bench/mgmt_station.sv */
// Purpose: management station and transmit side model
// Assumes: requests are taken on the rising clk edge
// Notes: reserved fields are always written with their zero defaults
`timescale 1ns/1ps

module mgmt_station (
   input wire logic clk,
   input wire logic [15:0] rdata,
   input wire logic rvalid,
   output phy_stat_pkg::mgmt_req_t req,
   output logic tx_en,
   output logic tx_clk
);
   // --------
   // transmit
   // --------
   logic run;

   // link clock stands still low between frames
   initial begin
      req = '0;
      tx_en = 1'b0;
      tx_clk = 1'b0;
      run = 1'b0;
      #1.3;
      forever #40 tx_clk = run ? ~tx_clk : 1'b0;
   end

   task automatic tx_on();
      run = 1'b1;
      @(negedge tx_clk);
      tx_en = 1'b1;
   endtask : tx_on

   task automatic tx_off();
      @(negedge tx_clk);
      tx_en = 1'b0;
      run = 1'b0;
   endtask : tx_off

   // --------
   // register access
   // --------
   // idle address and data are inverted so stale values never look valid
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      req.addr = a;
      req.wdata = (a == phy_stat_pkg::CTRL_ADDR) ? (d & 16'hFF80) :
         (a == phy_stat_pkg::STAT_ADDR) ? (d & 16'hF87F) : d;
      req.wr = 1'b1;
      @(posedge clk);
      #1;
      req.wr = 1'b0;
      req.addr = ~req.addr;
      req.wdata = ~req.wdata;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [15:0] q);
      @(posedge clk);
      #1;
      req.addr = a;
      req.rd = 1'b1;
      @(posedge clk);
      #1;
      req.rd = 1'b0;
      req.addr = ~req.addr;
      // rvalid stands only in the cycle after the taking edge
      q = (rvalid === 1'b1) ? rdata : 16'hXXXX;
   endtask : rd
endmodule : mgmt_station

/* bench/tb_phy_stat_regs.sv */
// Purpose: self-checking bench for the status register block
// Assumes: 200 MHz clk, reset held for six cycles
// Notes: collision timing is counted in core clock cycles
`timescale 1ns/1ps

module tb_phy_stat_regs;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ovr = 1'b0;
   logic [4:0] evb = 5'h12;
   logic [15:0] q;
   logic [15:0] rdata;
   logic rvalid, col, tx_en, tx_clk;
   phy_stat_pkg::mgmt_req_t req;
   int err_total = 0;
   int n_compared = 0;
   int i;
   logic [4:0] v [4] = '{5'h1A, 5'h16, 5'h13, 5'h10};
   logic [15:0] f [4] = '{16'h782D, 16'h781D, 16'h780F, 16'h7809};

   always #2.5 clk = ~clk;

   phy_stat_regs u_dut (.clk(clk), .resetn(resetn), .req(req),
      .override_writable(ovr), .ev(phy_stat_pkg::stat_ev_t'(evb)),
      .tx_en(tx_en), .tx_clk(tx_clk), .rdata(rdata), .rvalid(rvalid),
      .col(col));

   mgmt_station u_sta (.clk(clk), .rdata(rdata), .rvalid(rvalid),
      .req(req), .tx_en(tx_en), .tx_clk(tx_clk));

   // --------
   // helpers
   // --------
   task automatic chk(input string what, input logic [15:0] e,
         input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task automatic rchk(input logic [4:0] a, input logic [15:0] e);
      u_sta.rd(a, q);
      chk($sformatf("reg %0d", a), e, q);
   endtask : rchk

   // bounded wait, so a stuck col is reported instead of hanging
   task automatic wait_col(input logic lvl, input int lim, input string w);
      int k;
      for (k = 0; k < lim && col !== lvl; k++) begin
         @(posedge clk);
         #1;
      end
      chk(w, {15'h0000, lvl}, {15'h0000, col});
   endtask : wait_col

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // --------
   // tests
   // --------
   initial begin
      repeat (6) @(posedge clk);
      #1;
      resetn = 1'b1;
      rchk(phy_stat_pkg::STAT_ADDR, 16'h7809);
      rchk(phy_stat_pkg::CTRL_ADDR, 16'h0000);
      rchk(5'h1F, 16'h0000);
      u_sta.wr(phy_stat_pkg::STAT_ADDR, 16'h0040);
      rchk(phy_stat_pkg::STAT_ADDR, 16'h780D);
      ovr = 1'b1;
      u_sta.wr(phy_stat_pkg::STAT_ADDR, 16'h07C0);
      rchk(phy_stat_pkg::STAT_ADDR, 16'h004D);
      u_sta.wr(phy_stat_pkg::STAT_ADDR, 16'hFFFF);
      rchk(phy_stat_pkg::STAT_ADDR, 16'h784D);
      u_sta.wr(phy_stat_pkg::STAT_ADDR, 16'h7800);
      ovr = 1'b0;
      // loopback on but collision test off: col must stay quiet
      u_sta.wr(phy_stat_pkg::CTRL_ADDR, 16'h4000);
      u_sta.tx_on();
      i = 0;
      repeat (300) begin
         @(posedge clk);
         #1;
         if (col !== 1'b0) i++;
      end
      u_sta.tx_off();
      chk("col quiet", 16'h0000, 16'(i));
      u_sta.wr(phy_stat_pkg::CTRL_ADDR, 16'h40FF);
      rchk(phy_stat_pkg::CTRL_ADDR, 16'h4080);
      u_sta.tx_on();
      wait_col(1'b1, 1024, "col rise");
      repeat (40) @(posedge clk);
      #1;
      chk("col hold", 16'h0001, {15'h0000, col});
      u_sta.tx_off();
      wait_col(1'b0, 8, "col fall");
      rchk(phy_stat_pkg::STAT_ADDR, 16'h780D);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         evb = v[i];
         @(posedge clk);
         #1;
         evb = 5'h12;
         rchk(phy_stat_pkg::STAT_ADDR, f[i]);
         rchk(phy_stat_pkg::STAT_ADDR, 16'h780D);
      end
      evb = 5'h0A;
      rchk(phy_stat_pkg::STAT_ADDR, 16'h780D);
      wrap_up();
   end

   initial begin
      #100000;
      err_total++;
      $display("MISMATCH watchdog expected done seen timeout");
      wrap_up();
   end
endmodule : tb_phy_stat_regs
